// ===== mgs_pkg.sv
// Shared constants for the management serial slave and its manager
package mgs_pkg;

    // ------------------------------------------------------------
    // Register addresses on the management link
    // ------------------------------------------------------------
    localparam logic [4:0] BASIC_CONTROL_ADDR = 5'h00;
    localparam logic [4:0] BASIC_STATUS_ADDR = 5'h01;
    localparam logic [4:0] IDENTIFIER_HIGH_ADDR = 5'h02;
    localparam logic [4:0] IDENTIFIER_LOW_ADDR = 5'h03;
    localparam logic [4:0] NEGOTIATION_ADVERTISE_ADDR = 5'h04;
    localparam logic [4:0] PARTNER_ABILITY_ADDR = 5'h05;
    localparam logic [4:0] NEGOTIATION_EXPANSION_ADDR = 5'h06;
    localparam logic [4:0] EXTENDED_STATUS_ADDR = 5'h0f;
    localparam logic [4:0] PIN_FUNCTION_CONFIG_ONE_ADDR = 5'h10;
    localparam logic [4:0] INTERRUPT_REGISTER_ADDR = 5'h11;
    localparam logic [4:0] PAGE_SELECT_REGISTER_ADDR = 5'h1f;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_DATAPATH_RESET_BIT = 15;
    localparam int CTRL_AN_ENABLE_BIT = 12;
    localparam int STATUS_LINK_BIT = 2;
    localparam int PIN_GLOBAL_RESET_BIT = 15;
    localparam int PIN_GENERAL_OUTPUT_ONE_SEL_LSB = 6;
    localparam int PIN_IO1_SEL_LSB = 3;
    localparam int PIN_IO3_SEL_LSB = 0;
    localparam int IRQ_ENABLE_LSB = 8;
    localparam int PAGE_SUMMARY_BIT = 15;

    // ------------------------------------------------------------
    // Reset and fixed values
    // ------------------------------------------------------------
    localparam logic AN_ENABLE_RST = 1'b1;
    localparam logic [15:0] ADVERTISE_RST = 16'h0020;
    localparam logic [15:0] BASIC_STATUS_VALUE = 16'h0109;
    localparam logic [15:0] EXPANSION_VALUE = 16'h0000;
    localparam logic [15:0] EXTENDED_STATUS_VALUE = 16'h8000;
    localparam logic [5:0] PINS_RST = 6'h15;

    // ------------------------------------------------------------
    // Frame format and pin function codes
    // ------------------------------------------------------------
    localparam int PREAMBLE_ONES = 32;
    localparam int HEADER_BITS = 12;
    localparam int DATA_BITS = 16;
    localparam logic [1:0] START_CODE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] TA_WRITE = 2'h2;
    localparam logic [2:0] SEL_HIZ = 3'h0;
    localparam logic [2:0] SEL_LOW = 3'h1;
    localparam logic [2:0] SEL_HIGH = 3'h2;
    localparam logic [2:0] SEL_IRQ = 3'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CORE_PERIOD_NS = 4;
    localparam int MDC_MIN_PERIOD_NS = 80;
    localparam int MDC_HALF_CYC = (MDC_MIN_PERIOD_NS + 2 * CORE_PERIOD_NS - 1) / (2 * CORE_PERIOD_NS);

    // ------------------------------------------------------------
    // Manager command registers on APB
    // ------------------------------------------------------------
    localparam logic [7:0] MGR_CMD_OFS = 8'h00;
    localparam logic [7:0] MGR_STATUS_OFS = 8'h04;
    localparam int CMD_GO_BIT = 31;
    localparam int CMD_SUPPRESS_BIT = 27;
    localparam int CMD_READ_BIT = 26;
    localparam int CMD_PHY_LSB = 21;
    localparam int CMD_REG_LSB = 16;
    localparam int STATUS_BUSY_BIT = 16;

endpackage

// ===== mgs_link_if.sv
// Two-wire management link between manager and device
`timescale 1ns/1ps
`default_nettype none
interface mgs_link_if;
    logic mdc;
    logic mgr_out;
    logic mgr_oe_n;
    logic dev_out;
    logic dev_oe_n;
    logic mdio;

    // Pulled-up shared data line
    assign mdio = !mgr_oe_n ? mgr_out : (!dev_oe_n ? dev_out : 1'b1);

    modport manager(output mdc, output mgr_out, output mgr_oe_n, input mdio);
    modport device(input mdc, input mdio, output dev_out, output dev_oe_n);
endinterface
`default_nettype wire

// ===== mgs_sync.sv
// Two-flop synchroniser for pins from outside the core clock
`timescale 1ns/1ps
`default_nettype none
module mgs_sync #(
    parameter int W = 1
) (
    // Clock
    input wire logic core_clk_i,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // No reset, so strap levels are valid right at reset release
    always_ff @(posedge core_clk_i) begin
        meta_q <= async_i;
        sync_o <= meta_q;
    end
endmodule
`default_nettype wire

// ===== mgs_device.sv
// Management serial slave end with reset and interrupt pin logic
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Always a management slave, never initiates
// - Frame: preamble, start, opcode, addresses, turnaround, data
// - Address and data fields go MSB first
// - Short or absent preamble is accepted
// - Manager sends 32 ones after reset
// - Suppressed preamble: one idle bit, then start
// - Act only on own station address
// - Station address strapped from data and error pins
// - Bad start or opcode locks until 32 ones
// - Full preamble after clause 45 traffic
// - Manager clock at most 12.5 MHz, shared line
// - Only the basic register subset is implemented
// - Hardware reset clears all but test logic
// - Pin levels sampled in reset as defaults
// - Hold hardware reset at least 100 us; the testbench holds it 20 cycles (80 ns)
// - Global reset bit acts as hardware reset
// - Self-clearing datapath reset spares the registers
// - Test port reset pin resets test logic only
// - Code 011 makes pin an active-low interrupt
// - Interrupt status and enables share one register
// - Page register holds summary, readable on all pages
// - Station address must not be all ones
module mgs_device
    import mgs_pkg::*;
#(
    parameter logic [15:0] ID_HIGH = 16'h0a5a, // Arbitrary value
    parameter logic [15:0] ID_LOW = 16'h5a50 // Arbitrary value
) (
    // Clock and resets
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic test_port_reset_pin_n_i,
    // Management link
    mgs_link_if.device link,
    // Reset straps
    input wire logic [3:0] rx_data_upper_i,
    input wire logic receive_error_pin_i,
    // Status inputs
    input wire logic [3:0] irq_event_i,
    input wire logic link_up_i,
    input wire logic [15:0] partner_ability_i,
    // Pins with selectable function
    output logic general_output_one_o,
    output logic general_output_one_oe_n_o,
    output logic general_io_one_o,
    output logic general_io_one_oe_n_o,
    output logic general_io_three_o,
    output logic general_io_three_oe_n_o,
    // Datapath control
    output logic datapath_reset_o,
    output logic an_enable_o,
    output logic [15:0] advertise_o,
    output logic test_logic_reset_o
);
    typedef enum logic [2:0] {DS_PRE, DS_START, DS_HDR, DS_TA, DS_DATA} mgs_dev_fsm_t;

    typedef struct packed {
        mgs_dev_fsm_t fsm;
        logic mdc_prev;
        logic strap_pend;
        logic [4:0] phy_addr;
        logic synced;
        logic [4:0] ones;
        logic [4:0] cnt;
        logic [11:0] hdr;
        logic hit;
        logic rd;
        logic [4:0] regad;
        logic [15:0] shift;
        logic mdio_o;
        logic mdio_oe_n;
        logic an_en;
        logic [15:0] adv;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic [4:0] page;
        logic [2:0] sel_general_output_one;
        logic [2:0] sel_io1;
        logic [2:0] sel_io3;
        logic soft_rst;
        logic dp_rst;
        logic [5:0] pins;
    } mgs_dev_t;

    localparam mgs_dev_t DEV_RESET = '{fsm: DS_PRE, strap_pend: 1'b1, mdio_oe_n: 1'b1, an_en: AN_ENABLE_RST,
                                       adv: ADVERTISE_RST, pins: PINS_RST, default: '0};

    mgs_dev_t s_q;
    mgs_dev_t s_d;
    logic [10:0] sync_s;
    logic mdc_s;
    logic mdio_s;
    logic [4:0] strap_s;
    logic [3:0] ev_s;
    logic rise;
    logic irq_act;
    logic [11:0] hdr_n;
    logic [15:0] wdata;
    logic [1:0] jtag_rst_q;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    mgs_sync #(.W(11)) u_sync (
        .core_clk_i(core_clk_i),
        .async_i({link.mdc, link.mdio, receive_error_pin_i, rx_data_upper_i, irq_event_i}),
        .sync_o(sync_s)
    );
    assign {mdc_s, mdio_s, strap_s, ev_s} = sync_s;

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    function automatic logic [15:0] reg_value(input mgs_dev_t s, input logic [4:0] a);
        logic [15:0] r;
        r = '0;
        unique case (a)
            BASIC_CONTROL_ADDR: r[CTRL_AN_ENABLE_BIT] = s.an_en;
            BASIC_STATUS_ADDR: begin
                r = BASIC_STATUS_VALUE;
                r[STATUS_LINK_BIT] = link_up_i;
            end
            IDENTIFIER_HIGH_ADDR: r = ID_HIGH;
            IDENTIFIER_LOW_ADDR: r = ID_LOW;
            NEGOTIATION_ADVERTISE_ADDR: r = s.adv;
            PARTNER_ABILITY_ADDR: r = partner_ability_i;
            NEGOTIATION_EXPANSION_ADDR: r = EXPANSION_VALUE;
            EXTENDED_STATUS_ADDR: r = EXTENDED_STATUS_VALUE;
            PIN_FUNCTION_CONFIG_ONE_ADDR: begin
                r[PIN_GENERAL_OUTPUT_ONE_SEL_LSB +: 3] = s.sel_general_output_one;
                r[PIN_IO1_SEL_LSB +: 3] = s.sel_io1;
                r[PIN_IO3_SEL_LSB +: 3] = s.sel_io3;
            end
            INTERRUPT_REGISTER_ADDR: begin
                r[3:0] = s.irq_stat;
                r[IRQ_ENABLE_LSB +: 4] = s.irq_en;
            end
            PAGE_SELECT_REGISTER_ADDR: begin
                r[4:0] = s.page;
                r[PAGE_SUMMARY_BIT] = |(s.irq_stat & s.irq_en);
            end
            default: r = '0;
        endcase
        return r;
    endfunction

    // Pin driver: {level, enable_n}
    function automatic logic [1:0] pin_drive(input logic [2:0] sel, input logic irq, input logic od);
        logic [1:0] p;
        case (sel)
            SEL_LOW: p = 2'h0;
            SEL_HIGH: p = 2'h2;
            SEL_IRQ: p = od ? {1'b0, !irq} : {!irq, 1'b0};
            default: p = 2'h1;
        endcase
        return p;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        rise = mdc_s && !s_q.mdc_prev;
        hdr_n = {s_q.hdr[10:0], mdio_s};
        wdata = {s_q.shift[14:0], mdio_s};
        irq_act = |(s_q.irq_stat & s_q.irq_en);
        s_d.mdc_prev = mdc_s;
        s_d.dp_rst = 1'b0;
        s_d.irq_stat = s_q.irq_stat | ev_s;
        if (s_q.strap_pend) begin
            s_d.phy_addr = strap_s;
            s_d.strap_pend = 1'b0;
        end
        // only answers frames, never starts one
        if (rise) begin
            unique case (s_q.fsm)
                DS_PRE: begin
                    if (mdio_s) begin
                        s_d.ones = s_q.ones + 5'd1;
                        if (s_q.ones == 5'(PREAMBLE_ONES - 1)) begin
                            s_d.synced = 1'b1;
                        end
                    end else if (s_q.synced) begin
                        s_d.fsm = DS_START;
                    end else begin
                        s_d.ones = '0;
                    end
                end
                DS_START: begin
                    s_d.cnt = '0;
                    if (mdio_s == START_CODE[0]) begin
                        s_d.fsm = DS_HDR;
                    end else begin
                        s_d.fsm = DS_PRE;
                        s_d.synced = 1'b0;
                        s_d.ones = '0;
                    end
                end
                DS_HDR: begin
                    s_d.hdr = hdr_n;
                    s_d.cnt = s_q.cnt + 5'd1;
                    if (s_q.cnt == 5'(HEADER_BITS - 1)) begin
                        s_d.cnt = '0;
                        s_d.regad = hdr_n[4:0];
                        s_d.hit = hdr_n[9:5] == s_q.phy_addr;
                        s_d.rd = hdr_n[11:10] == OP_READ;
                        s_d.shift = reg_value(s_q, hdr_n[4:0]);
                        if (hdr_n[11:10] != OP_READ && hdr_n[11:10] != OP_WRITE) begin
                            s_d.fsm = DS_PRE;
                            s_d.synced = 1'b0;
                            s_d.ones = '0;
                        end else begin
                            s_d.fsm = DS_TA;
                            if (hdr_n[9:5] == s_q.phy_addr && hdr_n[11:10] == OP_READ
                                && hdr_n[4:0] == INTERRUPT_REGISTER_ADDR) begin
                                s_d.irq_stat = ev_s;
                            end
                        end
                    end
                end
                DS_TA: begin
                    s_d.cnt = s_q.cnt + 5'd1;
                    if (s_q.hit && s_q.rd) begin
                        s_d.mdio_oe_n = 1'b0;
                        s_d.mdio_o = (s_q.cnt == '0) ? 1'b0 : s_q.shift[15];
                        if (s_q.cnt != '0) begin
                            s_d.shift = {s_q.shift[14:0], 1'b0};
                        end
                    end
                    if (s_q.cnt != '0) begin
                        s_d.fsm = DS_DATA;
                        s_d.cnt = '0;
                    end
                end
                DS_DATA: begin
                    s_d.cnt = s_q.cnt + 5'd1;
                    if (s_q.rd) begin
                        s_d.mdio_o = s_q.shift[15];
                        s_d.shift = {s_q.shift[14:0], 1'b0};
                    end else begin
                        s_d.shift = wdata;
                    end
                    if (s_q.cnt == 5'(DATA_BITS - 1)) begin
                        s_d.fsm = DS_PRE;
                        s_d.ones = '0;
                        s_d.mdio_oe_n = 1'b1;
                        s_d.mdio_o = 1'b0;
                        if (s_q.hit && !s_q.rd) begin
                            unique case (s_q.regad)
                                BASIC_CONTROL_ADDR: begin
                                    s_d.an_en = wdata[CTRL_AN_ENABLE_BIT];
                                    s_d.dp_rst = wdata[CTRL_DATAPATH_RESET_BIT];
                                end
                                NEGOTIATION_ADVERTISE_ADDR: s_d.adv = wdata;
                                PIN_FUNCTION_CONFIG_ONE_ADDR: begin
                                    s_d.sel_general_output_one = wdata[PIN_GENERAL_OUTPUT_ONE_SEL_LSB +: 3];
                                    s_d.sel_io1 = wdata[PIN_IO1_SEL_LSB +: 3];
                                    s_d.sel_io3 = wdata[PIN_IO3_SEL_LSB +: 3];
                                    s_d.soft_rst = wdata[PIN_GLOBAL_RESET_BIT];
                                end
                                INTERRUPT_REGISTER_ADDR: s_d.irq_en = wdata[IRQ_ENABLE_LSB +: 4];
                                PAGE_SELECT_REGISTER_ADDR: s_d.page = wdata[4:0];
                                default: s_d.page = s_q.page;
                            endcase
                        end
                    end
                end
                default: s_d.fsm = DS_PRE;
            endcase
        end
        s_d.pins = {pin_drive(s_q.sel_general_output_one, irq_act, 1'b0), pin_drive(s_q.sel_io1, irq_act, 1'b1),
                    pin_drive(s_q.sel_io3, irq_act, 1'b1)};
        if (s_q.soft_rst) begin
            s_d = DEV_RESET;
            s_d.mdc_prev = mdc_s;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= DEV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Test logic reset, untouched by the other resets
    always_ff @(posedge core_clk_i or negedge test_port_reset_pin_n_i) begin
        if (!test_port_reset_pin_n_i) begin
            jtag_rst_q <= 2'h3;
        end else begin
            jtag_rst_q <= {jtag_rst_q[0], 1'b0};
        end
    end

    assign link.dev_out = s_q.mdio_o;
    assign link.dev_oe_n = s_q.mdio_oe_n;
    assign {general_output_one_o, general_output_one_oe_n_o, general_io_one_o, general_io_one_oe_n_o,
            general_io_three_o, general_io_three_oe_n_o} = s_q.pins;
    assign datapath_reset_o = s_q.dp_rst;
    assign an_enable_o = s_q.an_en;
    assign advertise_o = s_q.adv;
    assign test_logic_reset_o = jtag_rst_q[1];
endmodule
`default_nettype wire

// ===== mgs_manager.sv
// Management station end, commanded over APB
`timescale 1ns/1ps
`default_nettype none
module mgs_manager
    import mgs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Management link
    mgs_link_if.manager link
);
    typedef enum logic {HS_IDLE, HS_RUN} mgs_mgr_fsm_t;

    typedef struct packed {
        mgs_mgr_fsm_t fsm;
        logic [4:0] div;
        logic mdc;
        logic [5:0] idx;
        logic sup;
        logic rd;
        logic [31:0] frame;
        logic [15:0] rdata;
        logic mdio_o;
        logic mdio_oe_n;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mgs_mgr_t;

    localparam mgs_mgr_t MGR_RESET = '{fsm: HS_IDLE, mdio_oe_n: 1'b1, default: '0};

    mgs_mgr_t s_q;
    mgs_mgr_t s_d;
    logic mdio_s;
    logic [5:0] pre_len;
    logic [5:0] pos;
    logic [1:0] drv;

    mgs_sync #(.W(1)) u_sync (
        .core_clk_i(core_clk_i),
        .async_i(link.mdio),
        .sync_o(mdio_s)
    );

    // Line state for bit i: {level, enable_n}
    function automatic logic [1:0] bit_drive(input logic [5:0] i, input logic sup, input logic rd,
                                             input logic [31:0] f);
        logic [5:0] pl;
        logic [5:0] p;
        pl = sup ? 6'd1 : 6'(PREAMBLE_ONES);
        p = i - pl;
        if (i < pl) begin
            return sup ? 2'h3 : 2'h2;
        end else if (rd && p >= 6'(2 + 2 + 10)) begin
            return 2'h3;
        end
        return {f[5'(6'd31 - p)], 1'b0};
    endfunction

    always_comb begin
        s_d = s_q;
        pre_len = s_q.sup ? 6'd1 : 6'(PREAMBLE_ONES);
        pos = s_q.idx - pre_len;
        drv = bit_drive(s_q.idx + 6'd1, s_q.sup, s_q.rd, s_q.frame);
        // APB: one wait state, then answer
        s_d.pready = psel_i && penable_i && !s_q.pready;
        s_d.pslverr = 1'b0;
        if (psel_i && penable_i && !s_q.pready) begin
            s_d.prdata = '0;
            if (paddr_i == MGR_STATUS_OFS) begin
                s_d.prdata[15:0] = s_q.rdata;
                s_d.prdata[STATUS_BUSY_BIT] = s_q.fsm == HS_RUN;
            end else if (paddr_i != MGR_CMD_OFS) begin
                s_d.pslverr = 1'b1;
            end
        end
        unique case (s_q.fsm)
            HS_IDLE: begin
                if (psel_i && penable_i && s_q.pready && pwrite_i && paddr_i == MGR_CMD_OFS
                    && pwdata_i[CMD_GO_BIT]) begin
                    s_d.fsm = HS_RUN;
                    s_d.sup = pwdata_i[CMD_SUPPRESS_BIT];
                    s_d.rd = pwdata_i[CMD_READ_BIT];
                    s_d.frame = {START_CODE, pwdata_i[CMD_READ_BIT] ? OP_READ : OP_WRITE,
                                 pwdata_i[CMD_PHY_LSB +: 5], pwdata_i[CMD_REG_LSB +: 5], TA_WRITE,
                                 pwdata_i[15:0]};
                    s_d.idx = '0;
                    s_d.div = '0;
                    s_d.mdc = 1'b0;
                    {s_d.mdio_o, s_d.mdio_oe_n} = bit_drive(6'd0, pwdata_i[CMD_SUPPRESS_BIT],
                                                            pwdata_i[CMD_READ_BIT], 32'h0000_0000);
                end
            end
            HS_RUN: begin
                s_d.div = s_q.div + 5'd1;
                if (s_q.div == 5'(MDC_HALF_CYC - 1)) begin
                    s_d.div = '0;
                    s_d.mdc = !s_q.mdc;
                    if (!s_q.mdc) begin
                        if (s_q.rd && s_q.idx >= pre_len && pos >= 6'(32 - DATA_BITS)) begin
                            s_d.rdata = {s_q.rdata[14:0], mdio_s};
                        end
                    end else if (s_q.idx == pre_len + 6'd31) begin
                        s_d.fsm = HS_IDLE;
                        s_d.mdio_oe_n = 1'b1;
                        s_d.mdio_o = 1'b0;
                    end else begin
                        s_d.idx = s_q.idx + 6'd1;
                        {s_d.mdio_o, s_d.mdio_oe_n} = drv;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= MGR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign link.mdc = s_q.mdc;
    assign link.mgr_out = s_q.mdio_o;
    assign link.mgr_oe_n = s_q.mdio_oe_n;
endmodule
`default_nettype wire

// ===== mgs_link_monitor.sv
// Protocol checks on the management link between the two ends
`timescale 1ns/1ps
`default_nettype none
module mgs_link_monitor (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Link signals
    input wire logic mdc,
    input wire logic mgr_oe_n,
    input wire logic dev_oe_n,
    input wire logic dev_out
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_dev_start;
        $fell(dev_oe_n) && !dev_out;
    endsequence
    sequence s_dev_end;
        ##[330:350] $rose(dev_oe_n);
    endsequence
    chk_no_contend: assert property (!mgr_oe_n |-> dev_oe_n) else $error("both ends drive the line");
    chk_mdc_high: assert property ($rose(mdc) |-> mdc [*8] ##1 mdc [*2]) else $error("clock high too short");
    chk_mdc_low: assert property ($fell(mdc) |-> !mdc [*8] ##1 !mdc [*2]) else $error("clock low too short");
    chk_ta_zero: assert property ($fell(dev_oe_n) |-> !dev_out) else $error("turnaround bit not zero");
    chk_read_len: assert property (s_dev_start |-> s_dev_end) else $error("read drive length wrong");
    chk_idle_bit: assert property ($rose(mgr_oe_n) |-> mgr_oe_n [*8]) else $error("idle bit too short");
    chk_reset_idle: assert property ($fell(rst_i) |-> dev_oe_n && mgr_oe_n && !mdc) else $error("link busy in reset");
    chk_slave_only: assert property ($rose(dev_oe_n) |-> mgr_oe_n) else $error("device released into drive");
endmodule
`default_nettype wire

// ===== mdio_mgmt_slave_reset_irq_tb_top.sv
// Testbench joining manager and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module mdio_mgmt_slave_reset_irq_tb_top
    import mgs_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic [15:0] ability = 16'h0000;
    logic [3:0] ev = 4'h0;
    wire logic [3:0] pins;
    logic [15:0] adv;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    mgs_link_if link_bus();
    always #2 core_clk_i = ~core_clk_i;
    mgs_manager i_mgs_manager (.core_clk_i(core_clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(), .link(link_bus));
    mgs_device i_mgs_device (.core_clk_i(core_clk_i), .rst_i(rst_i), .test_port_reset_pin_n_i(1'b1),
        .link(link_bus), .rx_data_upper_i(4'h3), .receive_error_pin_i(1'b0), .irq_event_i(ev),
        .link_up_i(1'b0), .partner_ability_i(ability), .general_output_one_o(pins[3]),
        .general_output_one_oe_n_o(pins[2]), .general_io_one_o(pins[1]), .general_io_one_oe_n_o(pins[0]),
        .general_io_three_o(), .general_io_three_oe_n_o(),
        .datapath_reset_o(), .an_enable_o(), .advertise_o(adv), .test_logic_reset_o());
    mgs_link_monitor i_mgs_link_monitor (.core_clk_i(core_clk_i), .rst_i(rst_i), .mdc(link_bus.mdc),
        .mgr_oe_n(link_bus.mgr_oe_n), .dev_oe_n(link_bus.dev_oe_n), .dev_out(link_bus.dev_out));
    task automatic summarize();
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk_i);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One frame: command, wait until idle, fetch read data
    task automatic mgmt(input logic rd, input logic sup, input logic [4:0] rg, input logic [15:0] d,
        output logic [15:0] q, input logic [4:0] phy = 5'h03);
        logic [31:0] r;
        apb(MGR_CMD_OFS, 1'b1, {1'b1, 3'h0, sup, rd, phy, rg, d}, r);
        r = 32'h0001_0000;
        while (r[STATUS_BUSY_BIT] !== 1'b0) apb(MGR_STATUS_OFS, 1'b0, 32'h0000_0000, r);
        q = r[15:0];
        repeat (8) @(posedge core_clk_i);
    endtask
    task automatic t_write_read();
        logic [15:0] q;
        mgmt(1'b0, 1'b0, NEGOTIATION_ADVERTISE_ADDR, 16'h1234, q);
        chk(adv, 16'h1234);
        mgmt(1'b1, 1'b1, NEGOTIATION_ADVERTISE_ADDR, 16'h0000, q);
        chk(q, 16'h1234);
    endtask
    task automatic t_wrong_addr();
        logic [15:0] q;
        mgmt(1'b0, 1'b1, NEGOTIATION_ADVERTISE_ADDR, 16'h0f0f, q, 5'h05);
        chk(adv, 16'h1234);
        mgmt(1'b1, 1'b1, NEGOTIATION_ADVERTISE_ADDR, 16'h0000, q, 5'h05);
        chk(q, 16'hffff);
    endtask
    task automatic t_fixed();
        logic [15:0] q;
        @(posedge core_clk_i);
        ability <= 16'h4321;
        mgmt(1'b1, 1'b1, PARTNER_ABILITY_ADDR, 16'h0000, q);
        chk(q, 16'h4321);
        mgmt(1'b1, 1'b1, EXTENDED_STATUS_ADDR, 16'h0000, q);
        chk(q, EXTENDED_STATUS_VALUE);
    endtask
    task automatic t_global();
        logic [15:0] q;
        mgmt(1'b0, 1'b1, PIN_FUNCTION_CONFIG_ONE_ADDR, 16'h8000, q);
        chk(adv, ADVERTISE_RST);
        mgmt(1'b1, 1'b0, NEGOTIATION_ADVERTISE_ADDR, 16'h0000, q);
        chk(q, ADVERTISE_RST);
    endtask
    task automatic t_irq();
        logic [15:0] q;
        mgmt(1'b0, 1'b1, INTERRUPT_REGISTER_ADDR, 16'h0100, q);
        mgmt(1'b0, 1'b1, PIN_FUNCTION_CONFIG_ONE_ADDR, 16'h00d8, q);
        chk({12'h000, pins}, 16'h0009);
        ev <= 4'h1;
        repeat (6) @(posedge core_clk_i);
        chk({12'h000, pins}, 16'h0000);
        mgmt(1'b1, 1'b1, PAGE_SELECT_REGISTER_ADDR, 16'h0000, q);
        chk(q, 16'h8000);
        ev <= 4'h0;
        mgmt(1'b1, 1'b1, INTERRUPT_REGISTER_ADDR, 16'h0000, q);
        chk(q, 16'h0101);
        mgmt(1'b1, 1'b1, INTERRUPT_REGISTER_ADDR, 16'h0000, q);
        chk(q, 16'h0100);
        chk({12'h000, pins}, 16'h0009);
    endtask
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_write_read();
        t_wrong_addr();
        t_fixed();
        t_global();
        t_irq();
        summarize();
    end
endmodule
`default_nettype wire
